//--- rtl/frut_timer.sv
`timescale 1ns/1ps
`include "frut_defs.svh"
module frut_timer #(
    parameter int TICK_DIV = `FRUT_TICK_DIV,
    parameter int CNT_W    = 12
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     reset_n_i,
    input  wire frut_pkg::frut_rd_req_type rd_req_i,
    output frut_pkg::frut_rd_rsp_type      rd_rsp_o,
    input  wire logic                     short_irq_en_i,
    input  wire logic                     long_irq_en_i,
    output logic                          short_irq_o,
    output logic                          long_irq_o
);
    import frut_pkg::*;

    // upper counter bits that the holding register keeps
    localparam int               HI_W      = CNT_W - 8;
    localparam int               SHORT_BIT = `FRUT_SHORT_BIT;
    localparam int               LONG_BIT  = `FRUT_LONG_BIT;
    localparam logic [CNT_W-1:0] CNT_RST   = CNT_W'(`FRUT_CNT_RESET);
    localparam logic [HI_W-1:0]  HOLD_RST  = HI_W'(`FRUT_HOLD_RESET);

    // true when a read strobe addresses the given register
    function automatic logic addr_hit(
        input frut_rd_req_type req,
        input logic [7:0]      addr
    );
        logic match;
        match = req.rd && (req.addr == addr);
        return match;
    endfunction : addr_hit

    // level is high now and was low at the previous sample
    function automatic logic rose(
        input logic now_level,
        input logic last_level
    );
        return now_level && !last_level;
    endfunction : rose

    // data for the addressed register, zero when nothing is read
    function automatic logic [7:0] read_mux(
        input logic             sel_low,
        input logic             sel_high,
        input logic [CNT_W-1:0] count,
        input logic [HI_W-1:0]  held
    );
        logic [7:0] data;
        data = 8'h00;
        case ({sel_low, sel_high})
            2'b10: begin
                data = count[7:0];
            end
            2'b01: begin
                data = 8'(held);
            end
            default: begin
                data = 8'h00;
            end
        endcase
        return data;
    endfunction : read_mux

    // tick and counter
    logic             tick;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] cnt_inc;
    logic             cnt_max;

    // read decode and holding register
    logic             rd_low;
    logic             rd_high;
    logic [HI_W-1:0]  cnt_hi;
    logic [HI_W-1:0]  hold_q;
    logic [HI_W-1:0]  hold_d;

    // read response
    logic             rsp_valid_q;
    logic             rsp_valid_d;
    logic [7:0]       rsp_data_q;
    logic [7:0]       rsp_data_d;

    // short period request
    logic             short_lvl;
    logic             short_q;
    logic             short_d;
    logic             short_rise;
    logic             short_irq_q;
    logic             short_irq_d;

    // long period request
    logic             long_lvl;
    logic             long_q;
    logic             long_d;
    logic             long_rise;
    logic             long_irq_q;
    logic             long_irq_d;

    // divides the clock down to the one microsecond tick;
    // a parameter so that simulation may shorten it
    frut_tick_gen #(.DIV(TICK_DIV)) u_tick (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .tick_o    (tick)
    );

    // free running count of microseconds since reset;
    // all ones steps back to zero so differences stay valid across a wrap
    assign cnt_max = (cnt_q == '1);
    assign cnt_inc = cnt_max ? CNT_W'(0) : cnt_q + CNT_W'(1); // see RQ9
    assign cnt_d   = tick ? cnt_inc : cnt_q;                  // see RQ1

    // one decode per register address
    assign rd_low  = addr_hit(rd_req_i, `FRUT_ADDR_LOW);  // see RQ7
    assign rd_high = addr_hit(rd_req_i, `FRUT_ADDR_HIGH); // see RQ8

    // a low read latches the upper bits as they stand in that cycle,
    // so a carry that follows cannot split the two halves
    assign cnt_hi = cnt_q[CNT_W-1:8];
    assign hold_d = rd_low ? cnt_hi : hold_q; // see RQ2

    // high read returns latched bits, never the live counter;
    // any other address leaves the response at zero
    assign rsp_valid_d = rd_low || rd_high;
    assign rsp_data_d  = read_mux(rd_low, rd_high, cnt_q, hold_q); // see RQ3

    // edge detectors compare each bit with its value one cycle earlier
    assign short_lvl  = cnt_q[SHORT_BIT];
    assign short_d    = short_lvl;
    assign short_rise = rose(short_lvl, short_q); // see RQ4
    assign long_lvl   = cnt_q[LONG_BIT];
    assign long_d     = long_lvl;
    assign long_rise  = rose(long_lvl, long_q);   // see RQ4

    // requests are one-cycle pulses, raised only while enabled;
    // latching them until serviced is left to the interrupt controller
    assign short_irq_d = short_rise && short_irq_en_i; // see RQ5
    assign long_irq_d  = long_rise && long_irq_en_i;   // see RQ5

    // registers, one block each so every reset value sits by its register

    // counter advances on each tick
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // holding register for the upper bits
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_q <= HOLD_RST;
        end else begin
            hold_q <= hold_d;
        end
    end

    // response valid stands one cycle
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= rsp_valid_d;
        end
    end

    // response data, zero between reads
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsp_data_q <= 8'h00;
        end else begin
            rsp_data_q <= rsp_data_d;
        end
    end

    // previous value of the short period bit
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            short_q <= 1'b0;
        end else begin
            short_q <= short_d;
        end
    end

    // previous value of the long period bit
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            long_q <= 1'b0;
        end else begin
            long_q <= long_d;
        end
    end

    // short period request pulse
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            short_irq_q <= 1'b0;
        end else begin
            short_irq_q <= short_irq_d;
        end
    end

    // long period request pulse
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            long_irq_q <= 1'b0;
        end else begin
            long_irq_q <= long_irq_d;
        end
    end

    // outputs come straight from flip-flops
    assign rd_rsp_o    = '{valid: rsp_valid_q, data: rsp_data_q};
    assign short_irq_o = short_irq_q;
    assign long_irq_o  = long_irq_q;
endmodule : frut_timer

//--- rtl/frut_defs.svh
// Notes on behaviour
// RQ1: 12-bit counter advances once per microsecond tick
// RQ2: low byte read latches upper four bits
// RQ3: upper read returns holding register, not counter
// RQ4: two interrupt sources, 128 us and 1.024 ms
// RQ5: requests on rising bit 6/bit 9, if enabled
// RQ6: firmware times events by subtracting two readings
// RQ7: low eight bits readable at address 0x24
// RQ8: latched upper four bits readable at 0x25
// RQ9: counter wraps to zero; reset clears it
`ifndef FRUT_DEFS_SVH
`define FRUT_DEFS_SVH
`define FRUT_ADDR_LOW      8'h24
`define FRUT_ADDR_HIGH     8'h25
`define FRUT_CNT_RESET     12'h000
`define FRUT_HOLD_RESET    4'h0
`define FRUT_SHORT_BIT     6
`define FRUT_LONG_BIT      9
`define FRUT_CLK_HZ        50000000
`define FRUT_TICK_HZ       1000000
`define FRUT_TICK_DIV      (`FRUT_CLK_HZ / `FRUT_TICK_HZ)
`endif

//--- rtl/frut_pkg.sv
package frut_pkg;
    typedef struct packed {
        logic       rd;
        logic [7:0] addr;
    } frut_rd_req_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } frut_rd_rsp_type;
endpackage : frut_pkg

//--- rtl/frut_tick_gen.sv
`timescale 1ns/1ps
`include "frut_defs.svh"
module frut_tick_gen #(
    parameter int DIV = `FRUT_TICK_DIV
) (
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    output logic      tick_o
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] div_q;
    logic [W-1:0] div_d;
    logic         wrap;

    assign wrap   = (div_q == LAST);
    assign div_d  = wrap ? '0 : div_q + W'(1);
    assign tick_o = wrap;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) div_q <= '0;
        else            div_q <= div_d;
    end
endmodule : frut_tick_gen

//--- dv/frut_timer_monitor.sv
`timescale 1ns/1ps
module frut_timer_monitor import frut_pkg::*; (
    input wire logic            ref_clk_i,
    input wire logic            reset_n_i,
    input wire logic            short_irq_en_i,
    input wire logic            long_irq_en_i,
    input wire logic            short_irq_o,
    input wire logic            long_irq_o,
    input wire frut_rd_req_type rd_req_i,
    input wire frut_rd_rsp_type rd_rsp_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic hit   = rd_req_i.rd && rd_req_i.addr inside {8'h24, 8'h25};
    wire logic hi_rd = rd_req_i.rd && (rd_req_i.addr == 8'h25);
    // two high reads in a row, so no low read can fall between them
    sequence hi_pair_s;
        hi_rd ##1 hi_rd;
    endsequence
    rd_rsp_a: assert property (hit |=> rd_rsp_o.valid) else $error("rsp");
    no_rsp_a: assert property (!hit |=> rd_rsp_o == '0) else $error("rsp");
    hi_zero_a: assert property (hit && rd_req_i.addr[0] |=> !rd_rsp_o.data[7:4])
        else $error("hi");
    s_gap_a: assert property (short_irq_o |=> !short_irq_o [*8]) else $error("s");
    l_gap_a: assert property (long_irq_o |=> !long_irq_o [*8]) else $error("l");
    s_en_a: assert property (short_irq_o |-> $past(short_irq_en_i)) else $error("s");
    l_en_a: assert property (long_irq_o |-> $past(long_irq_en_i)) else $error("l");
    irq_apart_a: assert property (long_irq_o |-> !short_irq_o) else $error("l");
    hold_keep_a: assert property (hi_pair_s |=> rd_rsp_o.data == $past(rd_rsp_o.data))
        else $error("high read changed without a low read");
endmodule : frut_timer_monitor
bind frut_timer frut_timer_monitor u_mon (
    .ref_clk_i      (ref_clk_i),
    .reset_n_i      (reset_n_i),
    .short_irq_en_i (short_irq_en_i),
    .long_irq_en_i  (long_irq_en_i),
    .short_irq_o    (short_irq_o),
    .long_irq_o     (long_irq_o),
    .rd_req_i       (rd_req_i),
    .rd_rsp_o       (rd_rsp_o)
);

//--- dv/tb_frut_timer.sv
`timescale 1ns/1ps
module tb_frut_timer;
    import frut_pkg::*;
    logic            ref_clk_i      = 0;
    logic            reset_n_i      = 0;
    logic            short_irq_en_i = 0;
    logic            long_irq_en_i  = 0;
    logic            short_irq_o;
    logic            long_irq_o;
    frut_rd_req_type rd_req_i = '0;
    frut_rd_rsp_type rd_rsp_o;
    logic [8:0] l1, l2, h1, h2, hs;
    int err_total, checks_done, ns, nl, s0, l0;
    frut_timer #(.TICK_DIV(2)) DUT (.*);
    always #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) ns <= ns + short_irq_o;
    always @(posedge ref_clk_i) nl <= nl + long_irq_o;
    task automatic chk(input logic [8:0] got, exp);
        checks_done++;
        err_total += (got !== exp);
        if (got !== exp) $display("wrong value at %0t: %h", $time, got);
    endtask : chk
    task automatic rd(input logic [7:0] ad, output logic [8:0] d);
        @(posedge ref_clk_i) rd_req_i <= {1'b1, ad};
        @(posedge ref_clk_i) rd_req_i <= '0;
        #1 d = rd_rsp_o;
        @(posedge ref_clk_i);
    endtask : rd
    task automatic t_hold;
        rd(8'h26, l1);
        chk(l1, 9'h000);
        repeat (17) begin
            rd(8'h24, l1);
            rd(8'h25, h1);
            repeat (503) @(posedge ref_clk_i);
            rd(8'h25, hs);
            rd(8'h24, l2);
            rd(8'h25, h2);
            chk(hs, h1);
            chk(l2, l1);
            chk(h2, {5'h10, h1[3:0] + 4'h1});
            chk(9'({h2[3:0], l2[7:0]} - {h1[3:0], l1[7:0]}), 9'h100);
        end
    endtask : t_hold
    task automatic t_reset;
        @(posedge ref_clk_i) reset_n_i <= 1'b0;
        @(posedge ref_clk_i) #1 chk(9'({short_irq_o, long_irq_o}), 9'h000);
        repeat (6) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(8'h25, hs);
        chk(hs, 9'h100);
        rd(8'h24, l1);
        chk(l1, 9'h102);
        @(posedge ref_clk_i) rd_req_i <= {1'b1, 8'h25};
        @(posedge ref_clk_i) rd_req_i <= {1'b1, 8'h25};
        #1 hs = rd_rsp_o;
        @(posedge ref_clk_i) rd_req_i <= '0;
        #1 chk(rd_rsp_o, hs);
        chk(hs, 9'h100);
    endtask : t_reset
    task automatic t_irq(input logic s, l, input logic [8:0] es, el);
        @(posedge ref_clk_i) short_irq_en_i <= s;
        long_irq_en_i <= l;
        repeat (10) @(posedge ref_clk_i);
        #1 s0 = ns;
        l0 = nl;
        repeat (4096) @(posedge ref_clk_i);
        #1 chk(9'(ns - s0), es);
        chk(9'(nl - l0), el);
    endtask : t_irq
    task automatic results;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        t_hold();
        t_reset();
        t_irq(1'b1, 1'b0, 9'h010, 9'h000);
        t_irq(1'b0, 1'b1, 9'h000, 9'h002);
        results();
    end
    initial begin
        #800000 err_total++;
        results();
    end
endmodule : tb_frut_timer
